// ===== xpr_top.sv
// Purpose: Direct-read exit, power-up filtering, recovery sequence and reset recovery waits
// Assumes: Link pins arrive asynchronously and are sampled by CLK_I
// Notes:   Summary of operation follows
`include "xpr_params.svh"
`timescale 1ns/100ps
`default_nettype none

module xpr_top #(
    parameter int         SUPPLY_WAIT_CYC = `XPR_SUPPLY_WAIT_CYC,
    parameter logic [7:0] CMD_READ_STATUS = 8'h05,
    parameter logic [7:0] CMD_READ_FLAGS  = 8'h70
) (
    input  wire logic               CLK_I,
    input  wire logic               RST_I,
    input  wire logic               POWER_OK_I,
    input  wire logic               RESET_N_I,
    input  wire logic               HW_RESET_EN_I,
    input  wire logic               SCK_I,
    input  wire logic               SELECT_N_I,
    input  wire logic               DATA_LINE0_I,
    input  wire logic               DATA_LINE3_I,
    input  wire xpr_pkg::xpr_proto_e NV_PROTO_I,
    input  wire logic               NV_XIP_I,
    input  wire logic               FIRST_DUMMY_I,
    input  wire logic               SW_RESET_I,
    input  wire logic               DEEP_PD_I,
    input  wire logic               ARRAY_BUSY_I,
    input  wire logic               SR_WRITE_BUSY_I,
    input  wire logic               NVCR_WRITE_BUSY_I,
    output logic                    CORE_RESET_O,
    output logic                    POWERUP_O,
    output logic                    STANDBY_O,
    output var xpr_pkg::xpr_cmd_s   CMD_O,
    output var xpr_pkg::xpr_init_s  INIT_O,
    output var xpr_pkg::xpr_proto_e PROTO_O,
    output logic                    XIP_O,
    output logic                    SELECT_READY_O
);
    function automatic logic [4:0] frame_len(input xpr_pkg::xpr_proto_e p);
        unique case (p)
            xpr_pkg::XPR_PROTO_QUAD: frame_len = 5'(`XPR_EXIT_QUAD_CYC);
            xpr_pkg::XPR_PROTO_DUAL: frame_len = 5'(`XPR_EXIT_DUAL_CYC);
            default:                 frame_len = 5'(`XPR_EXIT_EXT_CYC);
        endcase
    endfunction

    function automatic xpr_pkg::xpr_proto_e stage_proto(input logic [1:0] s);
        unique case (s)
            2'h0:    stage_proto = xpr_pkg::XPR_PROTO_QUAD;
            2'h1:    stage_proto = xpr_pkg::XPR_PROTO_DUAL;
            default: stage_proto = xpr_pkg::XPR_PROTO_EXT;
        endcase
    endfunction

    xpr_pkg::xpr_pins_s pins_raw;
    xpr_pkg::xpr_pins_s pins;
    assign pins_raw = '{POWER_OK_I, RESET_N_I, SCK_I, SELECT_N_I, DATA_LINE0_I, DATA_LINE3_I};

    xpr_sync #(
        .W       (6),
        .RST_VAL (`XPR_PIN_RST_VAL)
    ) u_sync (
        .clk_i (CLK_I),
        .rst_i (RST_I),
        .d_i   (pins_raw),
        .q_o   (pins)
    );

    // Edge finding on the synchronised link
    logic sck_q;
    logic sel_q;
    logic rstn_q;
    logic sck_rise;
    logic frame_start;
    logic frame_end;
    logic hw_rst_on;
    logic hw_rst_rel;

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            sck_q  <= 1'b0;
            sel_q  <= 1'b1;
            rstn_q <= 1'b1;
        end else begin
            sck_q  <= pins.sck;
            sel_q  <= pins.select_n;
            rstn_q <= pins.reset_n;
        end
    end

    assign sck_rise    = pins.sck & ~sck_q;
    assign frame_start = ~pins.select_n & sel_q;
    assign frame_end   = pins.select_n & ~sel_q;
    assign hw_rst_on   = HW_RESET_EN_I & ~pins.reset_n;
    assign hw_rst_rel  = HW_RESET_EN_I & pins.reset_n & ~rstn_q;

    // Power state
    xpr_pkg::xpr_pwr_e pwr;
    xpr_pkg::xpr_pwr_e next_pwr;
    logic [15:0]       wait_cnt;
    logic [15:0]       next_wait_cnt;
    xpr_pkg::xpr_init_s next_init;

    always_comb begin
        next_pwr      = pwr;
        next_wait_cnt = wait_cnt;
        unique case (pwr)
            xpr_pkg::XPR_PWR_OFF: begin
                next_wait_cnt = 16'h0000;
                if (pins.power_ok) begin
                    next_pwr = xpr_pkg::XPR_PWR_PUP;
                end
            end
            xpr_pkg::XPR_PWR_PUP: begin
                next_wait_cnt = wait_cnt + 16'h0001;
                if (wait_cnt == 16'(SUPPLY_WAIT_CYC - 1)) begin
                    next_pwr = xpr_pkg::XPR_PWR_RDY;
                end
            end
            xpr_pkg::XPR_PWR_RDY: begin
                next_wait_cnt = wait_cnt;
            end
            default: begin
                next_pwr = xpr_pkg::XPR_PWR_OFF;
            end
        endcase
        if (!pins.power_ok) begin
            next_pwr = xpr_pkg::XPR_PWR_OFF;
        end
        next_init = {3{pwr == xpr_pkg::XPR_PWR_PUP && next_pwr == xpr_pkg::XPR_PWR_RDY}};
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            pwr      <= xpr_pkg::XPR_PWR_OFF;
            wait_cnt <= 16'h0000;
            INIT_O   <= '0;
        end else begin
            pwr      <= next_pwr;
            wait_cnt <= next_wait_cnt;
            INIT_O   <= next_init;
        end
    end

    assign CORE_RESET_O = (pwr == xpr_pkg::XPR_PWR_OFF);
    assign POWERUP_O    = (pwr == xpr_pkg::XPR_PWR_PUP);
    assign STANDBY_O    = (pwr == xpr_pkg::XPR_PWR_RDY) & pins.select_n;

    // Reset recovery wait
    logic        rst_evt;
    logic        slow_class;
    logic        write_class;
    logic [15:0] rec_cnt;
    logic [15:0] next_rec_cnt;
    logic        hold_wr;
    logic        next_hold_wr;

    assign rst_evt     = SW_RESET_I | hw_rst_rel;
    assign slow_class  = DEEP_PD_I | ARRAY_BUSY_I;
    assign write_class = SR_WRITE_BUSY_I | NVCR_WRITE_BUSY_I;

    always_comb begin
        next_rec_cnt = (rec_cnt != 16'h0000) ? rec_cnt - 16'h0001 : rec_cnt;
        next_hold_wr = hold_wr & write_class;
        if (rst_evt) begin
            if (write_class) begin
                next_hold_wr = 1'b1;
                next_rec_cnt = 16'(`XPR_FAST_RECOV_CYC);
            end else if (slow_class) begin
                next_rec_cnt = 16'(`XPR_SLOW_RECOV_CYC);
            end else begin
                next_rec_cnt = 16'(`XPR_FAST_RECOV_CYC);
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rec_cnt <= 16'h0000;
            hold_wr <= 1'b0;
        end else begin
            rec_cnt <= next_rec_cnt;
            hold_wr <= next_hold_wr;
        end
    end

    assign SELECT_READY_O = (pwr != xpr_pkg::XPR_PWR_OFF) & (rec_cnt == 16'h0000) & ~hold_wr & ~hw_rst_on;

    // Frame capture
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic       d0_all;
    logic       next_d0_all;
    logic       d03_all;
    logic       next_d03_all;
    logic [7:0] shift;
    logic [7:0] next_shift;
    xpr_pkg::xpr_cmd_s next_cmd;
    logic       cmd_ok;

    always_comb begin
        next_cnt     = cnt;
        next_d0_all  = d0_all;
        next_d03_all = d03_all;
        next_shift   = shift;
        next_cmd     = '0;
        if (frame_start) begin
            next_cnt     = 5'h00;
            next_d0_all  = 1'b1;
            next_d03_all = 1'b1;
        end else if (sck_rise && !pins.select_n) begin
            next_cnt     = (cnt == 5'h1f) ? cnt : cnt + 5'h01;
            next_d0_all  = d0_all & pins.data_line0;
            next_d03_all = d03_all & pins.data_line0 & pins.data_line3;
            next_shift   = {shift[6:0], pins.data_line0};
            next_cmd.code = next_shift;
            next_cmd.valid = (cnt == 5'(`XPR_CMD_BITS - 1)) & cmd_ok;
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            cnt     <= 5'h00;
            d0_all  <= 1'b0;
            d03_all <= 1'b0;
            shift   <= 8'h00;
            CMD_O   <= '0;
        end else begin
            cnt     <= next_cnt;
            d0_all  <= next_d0_all;
            d03_all <= next_d03_all;
            shift   <= next_shift;
            CMD_O   <= next_cmd;
        end
    end

    // Mode and recovery sequence
    logic [1:0] stage;
    logic [1:0] next_stage;
    xpr_pkg::xpr_proto_e next_proto;
    logic       next_xip;
    logic       exit_hit;
    logic       ones_hit;

    assign cmd_ok = SELECT_READY_O & ~XIP_O & (PROTO_O == xpr_pkg::XPR_PROTO_EXT) &
                    ((pwr == xpr_pkg::XPR_PWR_RDY) ||
                     ({shift[6:0], pins.data_line0} == CMD_READ_STATUS) ||
                     ({shift[6:0], pins.data_line0} == CMD_READ_FLAGS));
    assign exit_hit = frame_end & d0_all & (cnt == frame_len(PROTO_O));
    assign ones_hit = frame_end & d03_all & (cnt == 5'(`XPR_ONES_BYTE_CYC));

    always_comb begin
        next_proto = PROTO_O;
        next_xip   = XIP_O;
        next_stage = stage;
        if (pwr == xpr_pkg::XPR_PWR_OFF) begin
            next_proto = NV_PROTO_I;
            next_xip   = NV_XIP_I;
            next_stage = 2'h0;
        end else if (rst_evt || hw_rst_on) begin
            next_proto = NV_PROTO_I;
            next_xip   = NV_XIP_I;
            next_stage = 2'h0;
        end else begin
            if (exit_hit && XIP_O) begin
                next_xip = 1'b0;
            end
            if (FIRST_DUMMY_I && XIP_O && pins.data_line0) begin
                next_xip = 1'b0;
            end
            if (frame_end) begin
                if (stage == 2'(`XPR_LAST_STAGE) && ones_hit) begin
                    next_proto = xpr_pkg::XPR_PROTO_EXT;
                    next_xip   = 1'b0;
                    next_stage = 2'h0;
                end else if (stage != 2'(`XPR_LAST_STAGE) && d0_all && cnt == frame_len(stage_proto(stage))) begin
                    next_stage = stage + 2'h1;
                end else if (d0_all && cnt == 5'(`XPR_EXIT_QUAD_CYC)) begin
                    next_stage = 2'h1;
                end else begin
                    next_stage = 2'h0;
                end
            end
        end
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            PROTO_O <= xpr_pkg::XPR_PROTO_EXT;
            XIP_O   <= 1'b0;
            stage   <= 2'h0;
        end else begin
            PROTO_O <= next_proto;
            XIP_O   <= next_xip;
            stage   <= next_stage;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);

    a_off_holds_core: assert property (pwr == xpr_pkg::XPR_PWR_OFF |=> !CMD_O.valid || pwr != xpr_pkg::XPR_PWR_OFF)
        else $error("command issued while below power threshold");
    a_pup_filter: assert property (CMD_O.valid && $past(pwr) == xpr_pkg::XPR_PWR_PUP |->
        (CMD_O.code == CMD_READ_STATUS || CMD_O.code == CMD_READ_FLAGS))
        else $error("disallowed command during power-up");
    a_pup_length: assert property (pwr == xpr_pkg::XPR_PWR_RDY && $past(pwr) == xpr_pkg::XPR_PWR_PUP |->
        $past(wait_cnt) == 16'(SUPPLY_WAIT_CYC - 1))
        else $error("power-up phase length wrong");
    a_init_pulse: assert property (pwr == xpr_pkg::XPR_PWR_PUP ##1 pwr == xpr_pkg::XPR_PWR_RDY |->
        INIT_O == 3'h7 ##1 INIT_O == 3'h0)
        else $error("power-up clear pulses wrong");
    a_force_exit: assert property (exit_hit && XIP_O && !rst_evt && !hw_rst_on && pins.power_ok |=>
        !XIP_O && !CORE_RESET_O)
        else $error("forced exit did not end direct read mode");
    a_recover_ext: assert property (frame_end && stage == 2'h3 && ones_hit && !rst_evt && !hw_rst_on &&
        pins.power_ok |=> PROTO_O == xpr_pkg::XPR_PROTO_EXT && !XIP_O && stage == 2'h0)
        else $error("recovery did not restore extended protocol");
    a_confirm_bit: assert property (FIRST_DUMMY_I && XIP_O && pins.data_line0 && pins.power_ok &&
        !rst_evt && !hw_rst_on && pwr != xpr_pkg::XPR_PWR_OFF |=> !XIP_O)
        else $error("confirmation bit did not end direct read mode");
    a_fast_recov: assert property (rst_evt && !slow_class && !write_class && pins.power_ok &&
        pwr != xpr_pkg::XPR_PWR_OFF ##1 !rst_evt [*2] |-> ##[0:1] SELECT_READY_O)
        else $error("short reset recovery too long");
    a_slow_hold: assert property (rst_evt && slow_class && !write_class |=> !SELECT_READY_O [*8])
        else $error("long reset recovery ended early");
    a_write_hold: assert property ((rst_evt || hold_wr) && write_class |=> !SELECT_READY_O)
        else $error("selection accepted during pending write");
endmodule // xpr_top

`default_nettype wire

// ===== xpr_params.svh
// Purpose: Offsets-free constant set for the direct-read exit and power recovery block
// Assumes: Block clock of 10 MHz
// Notes:   Wait and recovery cycle counts derive from the printed times; exit, ones-byte and command counts are link clocks
`ifndef XPR_PARAMS_SVH
`define XPR_PARAMS_SVH

`define XPR_CLK_MHZ          10
`define XPR_SUPPLY_WAIT_US   150
`define XPR_SUPPLY_WAIT_CYC  (`XPR_SUPPLY_WAIT_US * `XPR_CLK_MHZ)
`define XPR_FAST_RECOV_NS    40
`define XPR_FAST_RAW_CYC     ((`XPR_FAST_RECOV_NS * `XPR_CLK_MHZ) / 1000)
`define XPR_FAST_RECOV_CYC   ((`XPR_FAST_RAW_CYC < 1) ? 1 : `XPR_FAST_RAW_CYC)
`define XPR_SLOW_RECOV_US    30
`define XPR_SLOW_RECOV_CYC   (`XPR_SLOW_RECOV_US * `XPR_CLK_MHZ)
`define XPR_EXIT_QUAD_CYC    7
`define XPR_EXIT_DUAL_CYC    13
`define XPR_EXIT_EXT_CYC     25
`define XPR_ONES_BYTE_CYC    8
`define XPR_CMD_BITS         8
`define XPR_LAST_STAGE       3
`define XPR_PIN_RST_VAL      6'h14

`endif

// ===== xpr_pkg.sv
// Purpose: Types shared by the direct-read exit and power recovery block
// Assumes: Nothing beyond the constants header
// Notes:   Pin group order matches the synchroniser vector
package xpr_pkg;

    typedef enum logic [1:0] {
        XPR_PROTO_EXT  = 2'h0,
        XPR_PROTO_DUAL = 2'h1,
        XPR_PROTO_QUAD = 2'h2
    } xpr_proto_e;

    typedef enum logic [2:0] {
        XPR_PWR_OFF = 3'h1,
        XPR_PWR_PUP = 3'h2,
        XPR_PWR_RDY = 3'h4
    } xpr_pwr_e;

    typedef struct packed {
        logic power_ok;
        logic reset_n;
        logic sck;
        logic select_n;
        logic data_line0;
        logic data_line3;
    } xpr_pins_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } xpr_cmd_s;

    typedef struct packed {
        logic clr_write_enable;
        logic clr_write_busy;
        logic clr_lock_bits;
    } xpr_init_s;

endpackage

// ===== xpr_sync.sv
// Purpose: Two-stage synchroniser for a group of asynchronous levels
// Assumes: Inputs are slow against CLK_I
// Notes:   Only the second stage leaves the module
`timescale 1ns/100ps
`default_nettype none

module xpr_sync #(
    parameter int         W       = 6,
    parameter logic [5:0] RST_VAL = 6'h00
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stage1 <= RST_VAL[W-1:0];
            stage2 <= RST_VAL[W-1:0];
        end else begin
            stage1 <= d_i;
            stage2 <= stage1;
        end
    end

    assign q_o = stage2;
endmodule // xpr_sync

`default_nettype wire

// ===== xpr_host_model.sv
// Purpose: Host controller model driving the serial pins of the block
// Assumes: Link clock of 800 ns, made from four block clocks a phase
// Notes:   Link clock stands low between frames; released data lines flip
`timescale 1ns/100ps
`default_nettype none

module xpr_host_model (
    input  wire logic clk_i,
    output logic      sck_o,
    output logic      select_n_o,
    output logic      d0_o,
    output logic      d3_o
);
    initial begin
        sck_o      = 1'b0;
        select_n_o = 1'b1;
        d0_o       = 1'b0;
        d3_o       = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic open_frame(input logic v0, input logic v3);
        @(posedge clk_i);
        select_n_o <= 1'b0;
        d0_o       <= v0;
        d3_o       <= v3;
        wait_clk(4);
    endtask

    task automatic pulse_sck(input int n);
        repeat (n) begin
            sck_o <= 1'b1;
            wait_clk(4);
            sck_o <= 1'b0;
            wait_clk(4);
        end
    endtask

    task automatic close_frame();
        @(posedge clk_i);
        select_n_o <= 1'b1;
        d0_o       <= ~d0_o;
        d3_o       <= ~d3_o;
        wait_clk(4);
    endtask

    task automatic frame(input int n, input logic v0, input logic v3);
        open_frame(v0, v3);
        pulse_sck(n);
        close_frame();
    endtask

    task automatic send_cmd(input logic [7:0] c);
        open_frame(c[7], 1'b1);
        pulse_sck(1);
        for (int i = 6; i >= 0; i--) begin
            d0_o <= c[i];
            pulse_sck(1);
        end
        close_frame();
    endtask
endmodule // xpr_host_model

`default_nettype wire

// ===== tb_top.sv
// Purpose: Self-checking bench for the direct-read exit and recovery block
// Assumes: Short power-up wait parameter
// Notes:   Host model drives the link pins
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    localparam int PU = 400;
    logic                clk, rst, power_ok, reset_n, hw_en, nv_xip;
    logic                first_dummy, sw_reset, deep_pd, array_busy, sr_busy, nv_busy;
    logic                sck, sel_n, d0, d3;
    logic                core_reset, powerup, standby, direct_read_mode, sel_ready;
    xpr_pkg::xpr_proto_e nv_proto, proto;
    xpr_pkg::xpr_cmd_s   cmd;
    xpr_pkg::xpr_init_s  init_v;
    logic [2:0]          last_init;
    logic [7:0]          codes[$];
    int                  fails, compares, cyc, pu_cyc, n_init;
    int                  exit_len[3] = '{7, 13, 25};
    xpr_pkg::xpr_proto_e tab[3] = '{xpr_pkg::XPR_PROTO_QUAD, xpr_pkg::XPR_PROTO_DUAL, xpr_pkg::XPR_PROTO_EXT};

    xpr_top #(.SUPPLY_WAIT_CYC(PU)) dut (
        .CLK_I(clk), .RST_I(rst), .POWER_OK_I(power_ok), .RESET_N_I(reset_n),
        .HW_RESET_EN_I(hw_en), .SCK_I(sck), .SELECT_N_I(sel_n), .DATA_LINE0_I(d0),
        .DATA_LINE3_I(d3), .NV_PROTO_I(nv_proto), .NV_XIP_I(nv_xip), .FIRST_DUMMY_I(first_dummy),
        .SW_RESET_I(sw_reset), .DEEP_PD_I(deep_pd), .ARRAY_BUSY_I(array_busy),
        .SR_WRITE_BUSY_I(sr_busy), .NVCR_WRITE_BUSY_I(nv_busy), .CORE_RESET_O(core_reset),
        .POWERUP_O(powerup), .STANDBY_O(standby), .CMD_O(cmd), .INIT_O(init_v),
        .PROTO_O(proto), .XIP_O(direct_read_mode), .SELECT_READY_O(sel_ready));

    xpr_host_model host (.clk_i(clk), .sck_o(sck), .select_n_o(sel_n), .d0_o(d0), .d3_o(d3));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (powerup === 1'b1) pu_cyc = pu_cyc + 1;
        if (cmd.valid === 1'b1) codes.push_back(cmd.code);
        if (init_v !== 3'h0) begin
            n_init    = n_init + 1;
            last_init = init_v;
        end
        if (cyc == 20000) begin
            fails = fails + 1;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic step(input int n);
        tick(n);
        #1;
    endtask

    // Pulse the software reset and count cycles until selection is accepted
    task automatic rst_evt(input int exp);
        int c;
        tick(1);
        sw_reset <= 1'b1;
        tick(1);
        sw_reset <= 1'b0;
        c = 1;
        #1;
        while (sel_ready !== 1'b1 && c < 1000) begin
            step(1);
            c++;
        end
        chk("ready_wait", exp, c);
        tick(1);
    endtask

    task automatic dummy(input logic v, input logic exp);
        host.open_frame(v, 1'b0);
        first_dummy <= 1'b1;
        tick(1);
        first_dummy <= 1'b0;
        step(3);
        chk("xip_confirm", exp, direct_read_mode);
        host.close_frame();
    endtask

    initial begin
        {rst, power_ok, reset_n, hw_en, nv_xip} = 5'h14;
        {first_dummy, sw_reset, deep_pd, array_busy, sr_busy, nv_busy} = 6'h00;
        nv_proto = xpr_pkg::XPR_PROTO_EXT;
        {fails, compares, cyc, pu_cyc, n_init} = 160'h0;
        last_init = 3'h0;
        step(5);
        chk("core_reset", 1, core_reset);
        rst <= 1'b0;
        host.send_cmd(8'h05);
        step(2);
        chk("off_cmds", 0, codes.size());
        chk("core_reset", 1, core_reset);
        power_ok <= 1'b1;
        step(5);
        chk("powerup", 1, powerup);
        host.send_cmd(8'h9f);
        host.send_cmd(8'h05);
        host.send_cmd(8'h70);
        step(2);
        chk("pup_cmds", 2, codes.size());
        chk("pup_code0", 8'h05, codes[0]);
        chk("pup_code1", 8'h70, codes[1]);
        step(PU);
        chk("powerup", 0, powerup);
        chk("pup_len", PU, pu_cyc);
        chk("standby", 1, standby);
        chk("init_cnt", 1, n_init);
        chk("init_bits", 3'h7, last_init);
        host.send_cmd(8'h9f);
        step(2);
        chk("rdy_code", 8'h9f, codes[codes.size()-1]);
        for (int i = 0; i < 3; i++) begin
            tick(1);
            nv_proto <= tab[i];
            nv_xip   <= 1'b1;
            rst_evt(2);
            array_busy <= 1'b1;
            step(1);
            chk("xip_load", 1, direct_read_mode);
            chk("proto_load", tab[i], proto);
            host.frame(exit_len[i] - 1, 1'b1, 1'b0);
            step(1);
            chk("xip_short", 1, direct_read_mode);
            host.frame(exit_len[i], 1'b1, 1'b0);
            step(1);
            chk("xip_exit", 0, direct_read_mode);
            chk("no_reset", 0, core_reset);
            chk("no_init", 1, n_init);
            chk("proto_kept", tab[i], proto);
            array_busy <= 1'b0;
        end
        tick(1);
        nv_proto <= xpr_pkg::XPR_PROTO_EXT;
        rst_evt(2);
        dummy(1'b0, 1'b1);
        dummy(1'b1, 1'b0);
        tick(1);
        nv_proto <= xpr_pkg::XPR_PROTO_QUAD;
        rst_evt(2);
        host.frame(8, 1'b1, 1'b1);
        step(1);
        chk("proto_order", xpr_pkg::XPR_PROTO_QUAD, proto);
        for (int i = 0; i < 3; i++) host.frame(exit_len[i], 1'b1, 1'b0);
        step(1);
        chk("proto_part1", xpr_pkg::XPR_PROTO_QUAD, proto);
        host.frame(8, 1'b1, 1'b1);
        step(1);
        chk("proto_rec", xpr_pkg::XPR_PROTO_EXT, proto);
        chk("xip_rec", 0, direct_read_mode);
        deep_pd <= 1'b1;
        rst_evt(301);
        deep_pd    <= 1'b0;
        array_busy <= 1'b1;
        rst_evt(301);
        array_busy <= 1'b0;
        for (int i = 0; i < 2; i++) begin
            {sr_busy, nv_busy} <= 2'(i + 1);
            tick(1);
            sw_reset <= 1'b1;
            tick(1);
            sw_reset <= 1'b0;
            step(50);
            chk("wr_wait", 0, sel_ready);
            tick(1);
            {sr_busy, nv_busy} <= 2'h0;
            step(4);
            chk("wr_done", 1, sel_ready);
        end
        tick(1);
        hw_en    <= 1'b1;
        nv_proto <= xpr_pkg::XPR_PROTO_DUAL;
        reset_n  <= 1'b0;
        step(6);
        chk("pin_low", 0, sel_ready);
        tick(1);
        reset_n <= 1'b1;
        step(8);
        chk("pin_ready", 1, sel_ready);
        chk("pin_proto", xpr_pkg::XPR_PROTO_DUAL, proto);
        chk("pin_xip", 1, direct_read_mode);
        tick(1);
        hw_en   <= 1'b0;
        reset_n <= 1'b0;
        step(6);
        chk("pin_off", 1, sel_ready);
        tick(1);
        power_ok <= 1'b0;
        step(6);
        chk("pdown", 1, core_reset);
        summarize();
    end
endmodule // tb_top

`default_nettype wire
